// ==== src/stop_wake_wdt_ctrl.v ====
// stop-mode wake, watchdog and brown-out reset control with apb registers
// assumes all pins synchronous to ref_clk; rcTick pulses once per microsecond
// of the internal rc oscillator; reset pin is open drain, driven low only
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "stop_wake_wdt_map.vh"

module stop_wake_wdt_ctrl #(
    parameter [`DELAY_CNT_W-1:0] POR_DELAY_CYCLES = `POR_DELAY_DEFAULT,
    parameter [`WDOG_CNT_W-1:0] WDOG_US0 = `WDOG_TO0_MS * `US_PER_MS,
    parameter [`WDOG_CNT_W-1:0] WDOG_US1 = `WDOG_TO1_MS * `US_PER_MS,
    parameter [`WDOG_CNT_W-1:0] WDOG_US2 = `WDOG_TO2_MS * `US_PER_MS,
    parameter [`WDOG_CNT_W-1:0] WDOG_US3 = `WDOG_TO3_MS * `US_PER_MS
) (
    input wire ref_clk,
    input wire srst,
    input wire [31:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    input wire port3Bit1Pin,
    input wire port3Bit2Pin,
    input wire port3Bit3Pin,
    input wire [7:0] port2Pins,
    input wire [7:0] port2IsInput,
    input wire stopReq,
    input wire haltMode,
    input wire rcTick,
    input wire watchdogTimerClearEnable,
    input wire shortResetClearEnable,
    input wire belowBrownout,
    input wire extResetN,
    input wire [`OTP_W-1:0] otpOptions,
    output reg sysReset_q,
    output reg stopMode_q,
    output reg resetPinOut_q,
    output reg resetPinOe_q,
    output reg [`OTP_PULLUP_HI:0] pullupEn_q,
    output reg readProtect_q,
    output reg irq_q
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_POR = 3'h0;
    localparam [2:0] ST_SHORT = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_STOP = 3'h3;
    localparam [2:0] ST_WAKEDLY = 3'h4;
    localparam [7:0] STOP_RECOV_INIT = `STOP_RECOV_RST;
    localparam [7:0] WDOG_MODE_INIT = `WDOG_MODE_RST;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg goWarm;
    reg goCold;
    reg [`WAKE_LEVEL_BIT:`WAKE_SRC_LO] stopRecov_q;
    reg warmStart_q;
    reg [`WDOG_STOP_BIT:0] wdogMode_q;
    reg wdogOn_q;
    reg optWdog_q;
    reg otpLoaded_q;
    reg [`IRQ_W-1:0] irqStatus_q;
    reg [`IRQ_W-1:0] irqMask_q;
    reg brownPrev_q;
    reg [4:0] usDiv_q;
    reg srcLevel;
    reg srcValid;
    reg [31:0] rdData;
    reg rdHit;
    reg [`WDOG_CNT_W-1:0] wdogLimit;

    wire [1:0] clrRise;
    wire wdogDone;
    wire delayDone;
    wire delayClear;
    wire [`DELAY_CNT_W-1:0] delayLimit;
    wire [2:0] wakeCode;
    wire [7:0] port2Eff;
    wire wakeHit;
    wire extRstSeen;
    wire usTick;
    wire wdogStep;
    wire wdogActive;
    wire wdogExpire;
    wire wdogClear;
    wire addrOk;
    wire wrFire;
    wire kickWrite;
    wire [`IRQ_W-1:0] irqEvents;

    // ----------------------------------------------------------------
    // edge detect of the two clear inputs
    // ----------------------------------------------------------------
    rise_detect #(
        .W(2)
    ) u_clr_rise (
        .ref_clk(ref_clk),
        .srst(srst),
        .level({shortResetClearEnable, watchdogTimerClearEnable}),
        .rise(clrRise)
    );

    // ----------------------------------------------------------------
    // wake source selection
    // ----------------------------------------------------------------
    assign wakeCode = stopRecov_q[`WAKE_SRC_HI:`WAKE_SRC_LO];
    assign port2Eff = port2Pins & port2IsInput;

    always @* begin
        srcValid = 1'b1;
        case (wakeCode)
            `WAKE_PORT3_BIT1: srcLevel = port3Bit1Pin;
            `WAKE_PORT3_BIT2: srcLevel = port3Bit2Pin;
            `WAKE_PORT3_BIT3: srcLevel = port3Bit3Pin;
            `WAKE_PORT2_BIT7: srcLevel = port2Pins[7];
            `WAKE_NOR_LOW: srcLevel = ~|port2Eff[3:0];
            `WAKE_NOR_ALL: srcLevel = ~|port2Eff;
            default: begin
                srcLevel = 1'b0;
                srcValid = 1'b0;
            end
        endcase
    end

    // level compare; a fast wake relies on the source staying active
    assign wakeHit = srcValid && (srcLevel == stopRecov_q[`WAKE_LEVEL_BIT]);

    // own pin drive is not an external reset
    assign extRstSeen = !extResetN && !resetPinOe_q;

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    assign usTick = (usDiv_q == (`REF_CLK_MHZ - 5'h01));
    assign wdogStep = (state_q == ST_STOP) ? rcTick : usTick;
    assign wdogActive = wdogOn_q
        && !(haltMode && !wdogMode_q[`WDOG_HALT_BIT])
        && !((state_q == ST_STOP) && !wdogMode_q[`WDOG_STOP_BIT]);
    assign kickWrite = wrFire && (paddr[`ADDR_LOW_W-1:0] == `ADDR_WDOG_CTRL) && pwdata[`WDOG_KICK_BIT];
    assign wdogClear = clrRise[0] || kickWrite || ((state_q != ST_RUN) && (state_q != ST_STOP));
    assign wdogExpire = wdogDone && ((state_q == ST_RUN) || (state_q == ST_STOP));

    always @* begin
        case (wdogMode_q[`WDOG_TIME_HI:`WDOG_TIME_LO])
            2'h0: wdogLimit = WDOG_US0;
            2'h1: wdogLimit = WDOG_US1;
            2'h2: wdogLimit = WDOG_US2;
            default: wdogLimit = WDOG_US3;
        endcase
    end

    interval_counter #(
        .W(`WDOG_CNT_W)
    ) u_wdog_cnt (
        .ref_clk(ref_clk),
        .srst(srst),
        .clear(wdogClear),
        .step(wdogActive && wdogStep),
        .limit(wdogLimit),
        .done_q(wdogDone)
    );

    always @(posedge ref_clk) begin
        if (srst || usTick) begin
            usDiv_q <= 5'h00;
        end else begin
            usDiv_q <= usDiv_q + 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        goWarm = 1'b0;
        goCold = 1'b0;
        if (belowBrownout) begin
            state_d = ST_POR;
            goCold = 1'b1;
        end else if (wdogExpire) begin
            state_d = ST_POR;
            goCold = 1'b1;
        end else if (clrRise[1]) begin
            state_d = ST_SHORT;
            goCold = 1'b1;
        end else if (extRstSeen && ((state_q != ST_STOP) || (wakeCode == `WAKE_RESET_ONLY))) begin
            state_d = ST_SHORT;
            goCold = 1'b1;
        end else begin
            case (state_q)
                ST_POR, ST_SHORT, ST_WAKEDLY: begin
                    if (delayDone) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (stopReq) begin
                        state_d = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (wakeHit) begin
                        goWarm = 1'b1;
                        if (stopRecov_q[`WAKE_DELAY_BIT]) begin
                            state_d = ST_WAKEDLY;
                        end else begin
                            state_d = ST_SHORT;
                        end
                    end
                end
                default: begin
                    state_d = ST_POR;
                end
            endcase
        end
    end

    assign delayLimit = (state_q == ST_SHORT) ? `SHORT_RST_CLKS : POR_DELAY_CYCLES;
    // restart on each entry; held clear while brown-out or external reset lasts
    assign delayClear = (state_d != state_q) || belowBrownout || extRstSeen;

    interval_counter #(
        .W(`DELAY_CNT_W)
    ) u_delay_cnt (
        .ref_clk(ref_clk),
        .srst(srst),
        .clear(delayClear),
        .step(1'b1),
        .limit(delayLimit),
        .done_q(delayDone)
    );

    always @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_POR;
            sysReset_q <= 1'b1;
            stopMode_q <= 1'b0;
            resetPinOut_q <= 1'b0;
            resetPinOe_q <= 1'b0;
            warmStart_q <= 1'b0;
            wdogOn_q <= 1'b0;
            brownPrev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sysReset_q <= (state_d != ST_RUN) && (state_d != ST_STOP);
            stopMode_q <= (state_d == ST_STOP);
            resetPinOe_q <= (state_d == ST_POR) && !belowBrownout;
            brownPrev_q <= belowBrownout;
            if (goWarm) begin
                warmStart_q <= 1'b1;
            end else if (goCold) begin
                warmStart_q <= 1'b0;
            end
            if (goCold) begin
                wdogOn_q <= 1'b0;
            end else if ((state_q == ST_POR) && (state_d == ST_RUN)) begin
                wdogOn_q <= optWdog_q;
            end else if (clrRise[0] || (wrFire && (paddr[`ADDR_LOW_W-1:0] == `ADDR_WDOG_CTRL)
                    && pwdata[`WDOG_EN_BIT])) begin
                wdogOn_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // one-time options, caught after reset release
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            otpLoaded_q <= 1'b0;
            pullupEn_q <= {(`OTP_PULLUP_HI + 1){1'b0}};
            readProtect_q <= 1'b0;
            optWdog_q <= 1'b0;
        end else if (!otpLoaded_q) begin
            otpLoaded_q <= 1'b1;
            pullupEn_q <= otpOptions[`OTP_PULLUP_HI:0];
            readProtect_q <= otpOptions[`OTP_PROTECT_BIT];
            optWdog_q <= otpOptions[`OTP_WDOG_AT_POR_BIT];
        end
    end

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    assign addrOk = (paddr[31:`ADDR_LOW_W] == {(32 - `ADDR_LOW_W){1'b0}}) && rdHit;
    assign wrFire = psel && penable && pwrite && pready_q && !pslverr_q;
    assign irqEvents = {belowBrownout && !brownPrev_q, wdogExpire, goWarm};

    always @* begin
        rdData = 32'h00000000;
        rdHit = 1'b1;
        case (paddr[`ADDR_LOW_W-1:0])
            `ADDR_STOP_RECOV: begin
                rdData[`WARM_START_BIT] = warmStart_q;
                rdData[`WAKE_LEVEL_BIT:`WAKE_SRC_LO] = stopRecov_q;
            end
            `ADDR_WDOG_MODE: rdData[`WDOG_STOP_BIT:0] = wdogMode_q;
            `ADDR_WDOG_CTRL: rdData[`WDOG_EN_BIT] = wdogOn_q;
            `ADDR_IRQ_STATUS: rdData[`IRQ_W-1:0] = irqStatus_q;
            `ADDR_IRQ_MASK: rdData[`IRQ_W-1:0] = irqMask_q;
            default: rdHit = 1'b0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !addrOk;
            prdata_q <= (addrOk && !pwrite) ? rdData : 32'h00000000;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // software registers and interrupt
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            stopRecov_q <= STOP_RECOV_INIT[`WAKE_LEVEL_BIT:`WAKE_SRC_LO];
            wdogMode_q <= WDOG_MODE_INIT[`WDOG_STOP_BIT:0];
            irqMask_q <= {`IRQ_W{1'b0}};
            irqStatus_q <= {`IRQ_W{1'b0}};
            irq_q <= 1'b0;
        end else begin
            if (wrFire && (paddr[`ADDR_LOW_W-1:0] == `ADDR_STOP_RECOV)) begin
                stopRecov_q <= pwdata[`WAKE_LEVEL_BIT:`WAKE_SRC_LO];
            end
            if (wrFire && (paddr[`ADDR_LOW_W-1:0] == `ADDR_WDOG_MODE)) begin
                wdogMode_q <= pwdata[`WDOG_STOP_BIT:0];
            end
            if (wrFire && (paddr[`ADDR_LOW_W-1:0] == `ADDR_IRQ_MASK)) begin
                irqMask_q <= pwdata[`IRQ_W-1:0];
            end
            // new events win over a write-one clear in the same cycle
            if (wrFire && (paddr[`ADDR_LOW_W-1:0] == `ADDR_IRQ_STATUS)) begin
                irqStatus_q <= (irqStatus_q & ~pwdata[`IRQ_W-1:0]) | irqEvents;
            end else begin
                irqStatus_q <= irqStatus_q | irqEvents;
            end
            irq_q <= |(irqStatus_q & irqMask_q);
        end
    end
endmodule // stop_wake_wdt_ctrl

// ==== src/stop_wake_wdt_map.vh ====
// stop recovery and watchdog block: register map, fields, reset values, timings
// assumes inclusion by each design file that needs a constant
`ifndef STOP_WAKE_WDT_MAP_VH
`define STOP_WAKE_WDT_MAP_VH

// ----------------------------------------------------------------
// apb map
// ----------------------------------------------------------------
`define ADDR_LOW_W 8
`define ADDR_STOP_RECOV 8'h00
`define ADDR_WDOG_MODE 8'h04
`define ADDR_WDOG_CTRL 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h10

// ----------------------------------------------------------------
// stop_recovery_control fields
// ----------------------------------------------------------------
`define WAKE_SRC_HI 4
`define WAKE_SRC_LO 2
`define WAKE_DELAY_BIT 5
`define WAKE_LEVEL_BIT 6
`define WARM_START_BIT 7
`define STOP_RECOV_RST 8'h20
`define WAKE_RESET_ONLY 3'h0
`define WAKE_PORT3_BIT1 3'h2
`define WAKE_PORT3_BIT2 3'h3
`define WAKE_PORT3_BIT3 3'h4
`define WAKE_PORT2_BIT7 3'h5
`define WAKE_NOR_LOW 3'h6
`define WAKE_NOR_ALL 3'h7

// ----------------------------------------------------------------
// watchdog_mode and watchdog control fields
// ----------------------------------------------------------------
`define WDOG_TIME_HI 1
`define WDOG_TIME_LO 0
`define WDOG_HALT_BIT 2
`define WDOG_STOP_BIT 3
`define WDOG_MODE_RST 8'h0D
`define WDOG_EN_BIT 0
`define WDOG_KICK_BIT 1

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define IRQ_W 3
`define IRQ_WAKE_BIT 0
`define IRQ_WDOG_BIT 1
`define IRQ_BROWNOUT_BIT 2

// ----------------------------------------------------------------
// one-time option bits
// ----------------------------------------------------------------
`define OTP_W 7
`define OTP_PULLUP_HI 4
`define OTP_PROTECT_BIT 5
`define OTP_WDOG_AT_POR_BIT 6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REF_CLK_MHZ 5'h19
`define US_PER_MS 17'h003E8
`define WDOG_TO0_MS 17'h00005
`define WDOG_TO1_MS 17'h0000A
`define WDOG_TO2_MS 17'h00014
`define WDOG_TO3_MS 17'h00050
`define WDOG_CNT_W 17
`define DELAY_CNT_W 20
`define SHORT_RST_CLKS 20'h00012
`define POR_DELAY_DEFAULT 20'h00190

`endif

// ==== src/rise_detect.v ====
// rising-edge detector for a group of synchronous inputs
// assumes inputs already synchronous to ref_clk
`timescale 1ns/1ns

module rise_detect #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire srst,
    input wire [W-1:0] level,
    output wire [W-1:0] rise
);
    reg [W-1:0] prev_q;

    always @(posedge ref_clk) begin
        if (srst) begin
            prev_q <= {W{1'b0}};
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
endmodule // rise_detect

// ==== src/interval_counter.v ====
// up-counter that flags when a programmable limit is reached
// assumes clear and step are synchronous; done holds until clear
`timescale 1ns/1ns

module interval_counter #(
    parameter W = 8
) (
    input wire ref_clk,
    input wire srst,
    input wire clear,
    input wire step,
    input wire [W-1:0] limit,
    output reg done_q
);
    reg [W-1:0] cnt_q;

    always @(posedge ref_clk) begin
        if (srst || clear) begin
            cnt_q <= {W{1'b0}};
            done_q <= 1'b0;
        end else if (step && !done_q) begin
            cnt_q <= cnt_q + 1'b1;
            done_q <= ((cnt_q + 1'b1) == limit);
        end
    end
endmodule // interval_counter

// ==== testbench/stop_wake_wdt_chk.sv ====
// checker: port timing of the stop wake and watchdog block
// assumes bind to stop_wake_wdt_ctrl; single clock domain
`timescale 1ns/1ns
module stop_wake_wdt_chk (
    input wire ref_clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire shortResetClearEnable,
    input wire belowBrownout,
    input wire extResetN,
    input wire [31:0] prdata_q,
    input wire pready_q,
    input wire pslverr_q,
    input wire sysReset_q,
    input wire stopMode_q,
    input wire resetPinOut_q,
    input wire resetPinOe_q
);
    reg [7:0] rstLen_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    always @(posedge ref_clk) begin
        if (srst || !sysReset_q)
            rstLen_q <= 8'h00;
        else if (rstLen_q != 8'hFF)
            rstLen_q <= rstLen_q + 8'h01;
    end
    a_ready_wait: assert property (psel && penable && !pready_q |=> pready_q)
        else $error("late ready");
    a_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("long ready");
    a_err_zero: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0)
        else $error("bad error reply");
    a_brownout_rst: assert property (belowBrownout |=> sysReset_q && !resetPinOe_q)
        else $error("brown-out reset missing");
    a_por_after: assert property ($fell(belowBrownout) |-> ##1 sysReset_q [*8])
        else $error("no power-on reset");
    a_pin_drive: assert property (resetPinOe_q |-> sysReset_q && !resetPinOut_q)
        else $error("stray pin drive");
    a_short_rst: assert property ($rose(shortResetClearEnable) |-> ##[1:3] sysReset_q)
        else $error("short reset not started");
    a_wake_rst: assert property ($fell(stopMode_q) |-> sysReset_q)
        else $error("stop left without reset");
    a_ext_rst: assert property (!extResetN && !resetPinOe_q && !stopMode_q |=> sysReset_q)
        else $error("ext reset ignored");
    a_rst_len: assert property ($fell(sysReset_q) |-> rstLen_q >= 8'h12)
        else $error("short pulse");
endmodule // stop_wake_wdt_chk

bind stop_wake_wdt_ctrl stop_wake_wdt_chk stop_wake_wdt_chk_inst (.*);

// ==== testbench/wake_partner.sv ====
// far side: wired reset line with pull-up and the rc oscillator ticks
// assumes ticks aligned to ref_clk, one per microsecond
`timescale 1ns/1ns
module wake_partner #(
    parameter TICK_DIV = 25
) (
    input wire ref_clk,
    input wire extPull,
    input wire resetPinOut_q,
    input wire resetPinOe_q,
    output wire extResetN,
    output reg rcTick
);
    integer div = 0;
    initial rcTick = 1'b0;
    // pulled up unless someone drives it low
    assign extResetN = !(extPull || (resetPinOe_q && !resetPinOut_q));
    // rc oscillator keeps running in stop
    always @(posedge ref_clk) begin
        div <= (div == TICK_DIV - 1) ? 0 : div + 1;
        rcTick <= (div == TICK_DIV - 1);
    end
endmodule // wake_partner

// ==== testbench/stop_wake_and_watchdog_control_tb.sv ====
// testbench: registers, wake sources, watchdog, brown-out, options
// assumes shortened delays; partner gives rc ticks and reset wire
`timescale 1ns/1ns
`include "stop_wake_wdt_map.vh"
module stop_wake_and_watchdog_control_tb;
    localparam [19:0] POR_N = 20'h14;
    reg ref_clk = 1'b0;
    reg srst = 1'b1;
    reg [31:0] paddr = 32'h0;
    reg [31:0] pwdata = 32'h0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg port3Bit1Pin = 1'b0;
    reg port3Bit2Pin = 1'b0;
    reg port3Bit3Pin = 1'b0;
    reg [7:0] port2Pins = 8'hFF;
    reg [7:0] port2IsInput = 8'hFF;
    reg stopReq = 1'b0;
    reg haltMode = 1'b0;
    reg watchdogTimerClearEnable = 1'b0;
    reg shortResetClearEnable = 1'b0;
    reg belowBrownout = 1'b0;
    reg extPull = 1'b0;
    reg [6:0] otpOptions = 7'h35;
    wire [31:0] prdata_q;
    wire pready_q, pslverr_q, sysReset_q, stopMode_q, resetPinOut_q, resetPinOe_q;
    wire readProtect_q, irq_q, rcTick, extResetN;
    wire [4:0] pullupEn_q;
    integer nFail = 0;
    integer checksDone = 0;
    integer i, k, n, lim;
    reg [31:0] rdv;
    reg errQ;
    reg [7:0] cfg;
    reg [7:0] cfgs [0:6];

    stop_wake_wdt_ctrl #(.POR_DELAY_CYCLES(POR_N), .WDOG_US0(17'h14), .WDOG_US1(17'h28),
        .WDOG_US2(17'h50), .WDOG_US3(17'h140)) stop_wake_wdt_ctrl_inst (.*);
    wake_partner wake_partner_inst (.ref_clk(ref_clk), .extPull(extPull), .resetPinOut_q(resetPinOut_q),
        .resetPinOe_q(resetPinOe_q), .extResetN(extResetN), .rcTick(rcTick));

    initial forever #20 ref_clk = ~ref_clk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp, input [8*12-1:0] what);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                nFail = nFail + 1;
                $display("wrong value at %0t: %0s got %h want %h", $time, what, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {24'h0, a};
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            t = 0;
            @(posedge ref_clk);
            while (pready_q !== 1'b1 && t < 20) begin
                t = t + 1;
                @(posedge ref_clk);
            end
            rdv = prdata_q;
            errQ = pslverr_q;
            psel <= 1'b0;
            penable <= 1'b0;
            if (t == 20) chk(0, 1, "apb hang");
        end
    endtask
    task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rdv & m, e, "register");
        end
    endtask
    task waitRst(input v, input integer l, output integer c);
        begin
            c = 0;
            while (sysReset_q !== v && c < l) begin
                c = c + 1;
                @(posedge ref_clk);
            end
            if (c == l) chk(0, 1, "reset wait");
        end
    endtask
    task setPins(input [7:0] c, input a);
        reg v;
        begin
            v = a ? c[6] : !c[6];
            port3Bit1Pin <= (c[4:2] == 3'h2) ? v : !c[6];
            port3Bit2Pin <= (c[4:2] == 3'h3) ? v : !c[6];
            port3Bit3Pin <= (c[4:2] == 3'h4) ? v : !c[6];
            port2IsInput <= (c[4:2] == 3'h7) ? 8'hFE : 8'hFF;
            if (c[4:2] == 3'h6)
                port2Pins <= a ? 8'hF0 : 8'hFF;
            else if (c[4:2] == 3'h7)
                port2Pins <= a ? 8'h01 : 8'hFF;
            else
                port2Pins <= {(c[4:2] == 3'h5) ? v : !c[6], 7'h7F};
        end
    endtask
    task enterStop;
        begin
            @(posedge ref_clk);
            stopReq <= 1'b1;
            @(posedge ref_clk);
            stopReq <= 1'b0;
            repeat (3) @(posedge ref_clk);
            chk(stopMode_q, 1, "stop entry");
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checksDone, nFail);
            if (nFail == 0 && checksDone > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        nFail = nFail + 1;
        conclude;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        cfgs[0] = 8'h48; cfgs[1] = 8'h4C; cfgs[2] = 8'h50; cfgs[3] = 8'h54;
        cfgs[4] = 8'h78; cfgs[5] = 8'h5C; cfgs[6] = 8'h08;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        waitRst(0, 200, n);
        chk(pullupEn_q, 5'h15, "pull-ups");
        chk(readProtect_q, 1, "protect");
        rdm(`ADDR_STOP_RECOV, 32'hFFFFFFFF, 32'h20);
        rdm(`ADDR_WDOG_MODE, 32'hFFFFFFFF, 32'h0D);
        rdm(`ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        rdm(8'h14, 32'hFFFFFFFF, 32'h0);
        chk(errQ, 1, "unmapped");
        apb(1'b1, `ADDR_STOP_RECOV, 32'hFF);
        rdm(`ADDR_STOP_RECOV, 32'hFFFFFFFF, 32'h7C);
        for (i = 0; i < 7; i = i + 1) begin
            cfg = cfgs[i];
            apb(1'b1, `ADDR_STOP_RECOV, {24'h0, cfg});
            setPins(cfg, 1'b0);
            enterStop;
            repeat (10) @(posedge ref_clk);
            chk(stopMode_q, 1, "no wake");
            setPins(cfg, 1'b1);
            n = 0;
            while (stopMode_q !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge ref_clk);
            end
            chk(stopMode_q, 0, "wake");
            waitRst(0, 200, n);
            chk(n, cfg[5] ? POR_N + 1 : 19, "wake delay");
            setPins(cfg, 1'b0);
            rdm(`ADDR_STOP_RECOV, 32'hFF, {24'h0, cfg | 8'h80});
            rdm(`ADDR_IRQ_STATUS, 32'h1, 32'h1);
            if (i == 0) begin
                chk(irq_q, 0, "masked irq");
                apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
                repeat (2) @(posedge ref_clk);
                chk(irq_q, 1, "irq");
            end
            apb(1'b1, `ADDR_IRQ_STATUS, 32'h7);
            repeat (2) @(posedge ref_clk);
            chk(irq_q, 0, "irq clear");
        end
        shortResetClearEnable <= 1'b1;
        waitRst(1, 5, n);
        waitRst(0, 200, n);
        chk(n, 19, "short reset");
        shortResetClearEnable <= 1'b0;
        rdm(`ADDR_STOP_RECOV, 32'h80, 32'h0);
        apb(1'b1, `ADDR_WDOG_MODE, 32'h0C);
        apb(1'b1, `ADDR_WDOG_CTRL, 32'h1);
        repeat (400) @(posedge ref_clk);
        apb(1'b1, `ADDR_WDOG_CTRL, 32'h2);
        repeat (300) @(posedge ref_clk);
        chk(sysReset_q, 0, "kick");
        waitRst(1, 600, n);
        waitRst(0, 200, n);
        apb(1'b1, `ADDR_WDOG_MODE, 32'h08);
        haltMode <= 1'b1;
        apb(1'b1, `ADDR_WDOG_CTRL, 32'h1);
        repeat (700) @(posedge ref_clk);
        chk(sysReset_q, 0, "halt");
        haltMode <= 1'b0;
        waitRst(1, 600, n);
        waitRst(0, 200, n);
        for (k = 0; k < 4; k = k + 1) begin
            lim = (k == 3) ? 320 * 25 : (20 << k) * 25;
            apb(1'b1, `ADDR_WDOG_MODE, 32'h0C | k);
            if (k == 3)
                watchdogTimerClearEnable <= 1'b1;
            else
                apb(1'b1, `ADDR_WDOG_CTRL, 32'h1);
            waitRst(1, lim + 100, n);
            chk(n >= lim - 25 && n <= lim + 40, 1, "timeout");
            chk(resetPinOe_q, 1, "pin drive");
            watchdogTimerClearEnable <= 1'b0;
            waitRst(0, 200, n);
            rdm(`ADDR_STOP_RECOV, 32'h80, 32'h0);
        end
        apb(1'b1, `ADDR_WDOG_MODE, 32'h04);
        apb(1'b1, `ADDR_WDOG_CTRL, 32'h1);
        apb(1'b1, `ADDR_STOP_RECOV, 32'h44);
        setPins(8'h00, 1'b0);
        enterStop;
        repeat (700) @(posedge ref_clk);
        chk(stopMode_q, 1, "reserved");
        chk(sysReset_q, 0, "stop wdog");
        belowBrownout <= 1'b1;
        repeat (40) @(posedge ref_clk);
        chk({sysReset_q, resetPinOe_q}, 2'b10, "brown-out");
        belowBrownout <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({sysReset_q, resetPinOe_q}, 2'b11, "por");
        waitRst(0, 200, n);
        rdm(`ADDR_STOP_RECOV, 32'h80, 32'h0);
        extPull <= 1'b1;
        waitRst(1, 5, n);
        extPull <= 1'b0;
        waitRst(0, 200, n);
        chk(n, 20, "ext reset");
        otpOptions <= 7'h40;
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        waitRst(0, 200, n);
        chk({pullupEn_q, readProtect_q}, 6'h00, "options");
        waitRst(1, 1300, n);
        conclude;
    end
endmodule // stop_wake_and_watchdog_control_tb
